// file: logic/led_matrix_i2c_command_port.sv
// Two-wire target port and LED register bank of the matrix LED driver.
`default_nettype none
module led_matrix_i2c_command_port
  import led_matrix_pkg::*;
(
  // Clock and reset.
  input  wire logic                             ref_clk,
  input  wire logic                             reset,
  // Serial bus pins.
  input  wire logic                             scl_in,
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe,
  // Address select pin.
  input  wire logic [1:0]                       ad_level,
  input  wire logic                             ad_is_touch_key,
  // Open and short detection results.
  input  wire logic                             fault_load,
  input  wire logic [led_matrix_pkg::FAULT_COUNT*8-1:0] fault_results,
  // Register contents for the LED engine.
  output logic [led_matrix_pkg::DOT_COUNT*8-1:0]   dot_duty,
  output logic [led_matrix_pkg::SCALE_COUNT*8-1:0] sink_scale_value,
  output logic [7:0]                            operating_config,
  output logic [6:0]                            global_current_code,
  output logic [7:0]                            pull_resistor_select,
  output logic [7:0]                            spread_spectrum_ctrl,
  output logic [7:0]                            output_frequency_select,
  output logic                                  display_enable
);
  import led_matrix_pkg::*;

  logic [7:0]  reg_q [REG_COUNT];
  logic        scl_q;
  logic        sda_q;
  logic        scl_p;
  logic        sda_p;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  port_state_t state_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [1:0]  phase_q;
  logic [1:0]  bank_q;
  logic        rw_q;
  logic [7:0]  ptr_q;
  logic [1:0]  low_address_bits;
  logic        wr_q;
  logic [7:0]  wr_addr_q;
  logic [7:0]  wr_data_q;
  logic        save_q;
  logic        srst_q;
  logic        oe_q;
  logic [7:0]  rd_byte;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  assign scl_rise   = scl_q & ~scl_p;
  assign scl_fall   = ~scl_q & scl_p;
  assign start_seen = scl_q & scl_p & sda_p & ~sda_q;
  assign stop_seen  = scl_q & scl_p & ~sda_p & sda_q;

  // The low address bits are refreshed every cycle from the pin strap, and forced to zero while ad_is_touch_key is set.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_address_bits <= 2'h0;
    end else if (ad_is_touch_key) begin
      low_address_bits <= 2'h0;
    end else begin
      low_address_bits <= ad_level;
    end
  end

  // Reads outside the LED bank return zero.
  assign rd_byte = (bank_q == BANK_LED) ? reg_q[ptr_q] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      phase_q   <= PH_ADDR;
      bank_q    <= BANK_NONE;
      rw_q      <= 1'b0;
      ptr_q     <= 8'h00;
      oe_q      <= 1'b0;
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      save_q    <= 1'b0;
      srst_q    <= 1'b0;
    end else begin
      wr_q   <= 1'b0;
      save_q <= 1'b0;
      srst_q <= 1'b0;
      if (stop_seen) begin
        state_q <= ST_IDLE;
        oe_q    <= 1'b0;
        bank_q  <= BANK_NONE;
      end else if (start_seen) begin
        state_q <= ST_RX;
        cnt_q   <= 4'h0;
        phase_q <= PH_ADDR;
        oe_q    <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && (cnt_q != BITS_PER_BYTE)) begin
              sh_q  <= {sh_q[6:0], sda_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && (cnt_q == BITS_PER_BYTE)) begin
              cnt_q <= 4'h0;
              unique case (phase_q)
                PH_ADDR: begin
                  if (sh_q[7:1] == {ADDR_UPPER, low_address_bits}) begin
                    rw_q    <= sh_q[0];
                    oe_q    <= 1'b1;
                    state_q <= ST_ACK;
                    if (!sh_q[0]) begin
                      phase_q <= PH_HDR;
                    end
                  end else begin
                    state_q <= ST_IDLE;
                  end
                end
                PH_HDR: begin
                  if (sh_q == HDR_LED) begin
                    bank_q <= BANK_LED;
                  end else if (sh_q == HDR_TOUCH) begin
                    bank_q <= BANK_TOUCH;
                  end else begin
                    bank_q <= BANK_NONE;
                  end
                  save_q  <= (sh_q == HDR_SAVE);
                  oe_q    <= 1'b1;
                  state_q <= ST_ACK;
                  phase_q <= PH_REG;
                end
                PH_REG: begin
                  ptr_q   <= sh_q;
                  oe_q    <= 1'b1;
                  state_q <= ST_ACK;
                  phase_q <= PH_DATA;
                end
                PH_DATA: begin
                  if (bank_q == BANK_LED) begin
                    wr_q      <= (ptr_q != SRST_ADDR);
                    srst_q    <= (ptr_q == SRST_ADDR) && (sh_q == SRST_KEY);
                    wr_addr_q <= ptr_q;
                    wr_data_q <= sh_q;
                  end
                  ptr_q   <= ptr_q + 8'h01;
                  oe_q    <= 1'b1;
                  state_q <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q    <= rd_byte;
                oe_q    <= ~rd_byte[7];
                state_q <= ST_TX;
              end else begin
                oe_q    <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == TX_LAST_FALL) begin
                oe_q    <= 1'b0;
                cnt_q   <= 4'h0;
                ptr_q   <= ptr_q + 8'h01;
                state_q <= ST_MACK;
              end else begin
                tx_q  <= {tx_q[6:0], 1'b0};
                oe_q  <= ~tx_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              rw_q <= ~sda_q;
            end else if (scl_fall) begin
              if (rw_q) begin
                tx_q    <= rd_byte;
                oe_q    <= ~rd_byte[7];
                state_q <= ST_TX;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // One storage byte per writable or fault address, other addresses read zero; saved defaults sit beside each writable byte.
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    localparam logic [7:0] ADDR = 8'(i);
    if (is_writable(ADDR)) begin : g_wr
      logic [7:0] dflt_q;
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          reg_q[i] <= power_on_value(ADDR);
        end else if (srst_q) begin
          reg_q[i] <= dflt_q;
        end else if (wr_q && (wr_addr_q == ADDR)) begin
          reg_q[i] <= wr_data_q;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          dflt_q <= power_on_value(ADDR);
        end else if (save_q) begin
          dflt_q <= reg_q[i];
        end
      end
    end else if (in_range(ADDR, FAULT_FIRST, FAULT_LAST)) begin : g_fault
      always_ff @(posedge ref_clk) begin
        if (reset || srst_q) begin
          reg_q[i] <= ZERO_RESET;
        end else if (fault_load) begin
          reg_q[i] <= fault_results[(i - int'(FAULT_FIRST))*8 +: 8];
        end
      end
    end else begin : g_none
      assign reg_q[i] = 8'h00;
    end
  end

  for (genvar d = 0; d < DOT_COUNT; d++) begin : g_dot
    assign dot_duty[d*8 +: 8] = reg_q[int'(DOT_FIRST) + d];
  end

  for (genvar s = 0; s < SCALE_COUNT; s++) begin : g_scale
    assign sink_scale_value[s*8 +: 8] = reg_q[int'(SCALE_FIRST) + s];
  end

  assign operating_config        = reg_q[CONFIG_ADDR];
  assign pull_resistor_select    = reg_q[PULL_ADDR];
  assign spread_spectrum_ctrl    = reg_q[SPREAD_ADDR];
  assign output_frequency_select = reg_q[FREQ_ADDR];
  assign sda_oe                  = oe_q;

  // Global current code saturates at its top step.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      global_current_code <= 7'h00;
      display_enable      <= 1'b0;
      sda_out             <= 1'b0;
    end else begin
      global_current_code <= (reg_q[GCC_ADDR][6:0] > GCC_MAX) ? GCC_MAX : reg_q[GCC_ADDR][6:0];
      display_enable      <= reg_q[CONFIG_ADDR][SSD_BIT];
      sda_out             <= 1'b0;
    end
  end
endmodule : led_matrix_i2c_command_port
`default_nettype wire

// file: shared/led_matrix_pkg.sv
// Constants, states and register map of the LED matrix serial command port.
`default_nettype none
package led_matrix_pkg;
  localparam logic [4:0] ADDR_UPPER     = 5'h0D;
  localparam logic [7:0] HDR_LED        = 8'h55;
  localparam logic [7:0] HDR_TOUCH      = 8'hAA;
  localparam logic [7:0] HDR_SAVE       = 8'hA5;
  localparam logic [7:0] DOT_FIRST      = 8'h01;
  localparam logic [7:0] DOT_LAST       = 8'h8F;
  localparam logic [7:0] SCALE_FIRST    = 8'h90;
  localparam logic [7:0] SCALE_LAST     = 8'h9F;
  localparam logic [7:0] CONFIG_ADDR    = 8'hA0;
  localparam logic [7:0] GCC_ADDR       = 8'hA1;
  localparam logic [7:0] PULL_ADDR      = 8'hB0;
  localparam logic [7:0] SPREAD_ADDR    = 8'hB1;
  localparam logic [7:0] FREQ_ADDR      = 8'hB2;
  localparam logic [7:0] FAULT_FIRST    = 8'hB3;
  localparam logic [7:0] FAULT_LAST     = 8'hC4;
  localparam logic [7:0] SRST_ADDR      = 8'hCF;
  localparam logic [7:0] SRST_KEY       = 8'hAE;
  localparam logic [7:0] PULL_RESET     = 8'h33;
  localparam logic [7:0] FREQ_RESET     = 8'h01;
  localparam logic [7:0] ZERO_RESET     = 8'h00;
  localparam logic [6:0] GCC_MAX        = 7'h40;
  localparam int         DOT_COUNT      = 143;
  localparam int         SCALE_COUNT    = 16;
  localparam int         FAULT_COUNT    = 18;
  localparam int         REG_COUNT      = 256;
  localparam int         SSD_BIT        = 0;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] TX_LAST_FALL   = 4'h7;
  localparam logic [1:0] PH_ADDR        = 2'h0;
  localparam logic [1:0] PH_HDR         = 2'h1;
  localparam logic [1:0] PH_REG         = 2'h2;
  localparam logic [1:0] PH_DATA        = 2'h3;
  localparam logic [1:0] BANK_NONE      = 2'h0;
  localparam logic [1:0] BANK_LED       = 2'h1;
  localparam logic [1:0] BANK_TOUCH     = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_MACK = 5'b10000
  } port_state_t;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic is_writable(input logic [7:0] a);
    is_writable = in_range(a, DOT_FIRST, DOT_LAST) || in_range(a, SCALE_FIRST, SCALE_LAST) ||
                  (a == CONFIG_ADDR) || (a == GCC_ADDR) || in_range(a, PULL_ADDR, FREQ_ADDR);
  endfunction : is_writable

  function automatic logic [7:0] power_on_value(input logic [7:0] a);
    if (a == PULL_ADDR) begin
      power_on_value = PULL_RESET;
    end else if (a == FREQ_ADDR) begin
      power_on_value = FREQ_RESET;
    end else begin
      power_on_value = ZERO_RESET;
    end
  endfunction : power_on_value
endpackage : led_matrix_pkg
`default_nettype wire

// file: verification/i2c_host_model.sv
// Bus master model that drives the two-wire port of the LED command port.
`default_nettype none
module i2c_host_model (
  // Clock.
  input  wire logic ref_clk,
  // Bus lines.
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half();
    repeat (5) @(posedge ref_clk);
  endtask : half
  // Start, also used as repeated start.
  task automatic start();
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask : stop
  task automatic xbit(input logic b, output logic r);
    half();
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
  endtask : xbit
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(~mack, r);
  endtask : get
endmodule : i2c_host_model
`default_nettype wire

// file: verification/led_port_checker.sv
// Assertions on the bus pin and register outputs of the LED command port.
`default_nettype none
module led_port_checker
  import led_matrix_pkg::*;
(
  // Clock and reset.
  input wire logic                                   ref_clk,
  input wire logic                                   reset,
  // Bus pins.
  input wire logic                                   scl_in,
  input wire logic                                   sda_out,
  input wire logic                                   sda_oe,
  // Register outputs.
  input wire logic [led_matrix_pkg::DOT_COUNT*8-1:0]   dot_duty,
  input wire logic [led_matrix_pkg::SCALE_COUNT*8-1:0] sink_scale_value,
  input wire logic [7:0]                             operating_config,
  input wire logic [6:0]                             global_current_code,
  input wire logic [7:0]                             pull_resistor_select,
  input wire logic [7:0]                             spread_spectrum_ctrl,
  input wire logic [7:0]                             output_frequency_select,
  input wire logic                                   display_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_scl_high;
    scl_in [*4];
  endsequence
  sequence s_ack_recent;
    sda_oe || $past(sda_oe) || $past(sda_oe, 2);
  endsequence
  property p_reset_values;
    $fell(reset) |-> !sda_oe && pull_resistor_select == 8'h33 && output_frequency_select == 8'h01 &&
      operating_config == 8'h00 && !display_enable;
  endproperty
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  property p_oe_rise;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  property p_oe_fall;
    $fell(sda_oe) |-> !scl_in;
  endproperty
  property p_oe_held;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  property p_ssd;
    $changed(operating_config[0]) |-> ##[0:2] display_enable == operating_config[0];
  endproperty
  property p_gcc;
    global_current_code <= 7'h40;
  endproperty
  property p_write_on_ack;
    $changed({dot_duty, sink_scale_value, operating_config, pull_resistor_select, spread_spectrum_ctrl,
      output_frequency_select}) |-> s_ack_recent;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad values after reset");
  a_open_drain: assert property (p_open_drain) else $error("data output not low");
  a_oe_rise: assert property (p_oe_rise) else $error("data pulled while clock high");
  a_oe_fall: assert property (p_oe_fall) else $error("data released while clock high");
  a_oe_held: assert property (p_oe_held) else $error("data moved during clock high");
  a_ssd: assert property (p_ssd) else $error("display enable not following config");
  a_gcc: assert property (p_gcc) else $error("global current above limit");
  a_write_on_ack: assert property (p_write_on_ack) else $error("register changed without ack");
endmodule : led_port_checker
bind led_matrix_i2c_command_port led_port_checker checker_i (
  .ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dot_duty(dot_duty), .sink_scale_value(sink_scale_value), .operating_config(operating_config),
  .global_current_code(global_current_code), .pull_resistor_select(pull_resistor_select),
  .spread_spectrum_ctrl(spread_spectrum_ctrl), .output_frequency_select(output_frequency_select),
  .display_enable(display_enable)
);
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench of the LED matrix serial command port.
`default_nettype none
module testbench;
  import led_matrix_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk = 1'b0;
  logic                     reset = 1'b1;
  logic [1:0]               ad_level = 2'h0;
  logic                     ad_is_touch_key = 1'b0;
  logic                     fault_load = 1'b0;
  logic [FAULT_COUNT*8-1:0] fault_results = '0;
  logic                     scl, sda_drv, sda_out, sda_oe, display_enable;
  logic [DOT_COUNT*8-1:0]   dot_duty;
  logic [SCALE_COUNT*8-1:0] sink_scale_value;
  logic [7:0]               operating_config, pull_resistor_select, spread_spectrum_ctrl, output_frequency_select;
  logic [6:0]               global_current_code;
  logic [1:0]               lo = 2'h0;
  int                       error_cnt = 0;
  int                       checked = 0;
  wire                      sda_line = sda_drv & ~sda_oe;
  always #5 ref_clk = ~ref_clk;
  i2c_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  led_matrix_i2c_command_port uut (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .ad_level(ad_level), .ad_is_touch_key(ad_is_touch_key), .fault_load(fault_load),
    .fault_results(fault_results), .dot_duty(dot_duty), .sink_scale_value(sink_scale_value),
    .operating_config(operating_config), .global_current_code(global_current_code),
    .pull_resistor_select(pull_resistor_select), .spread_spectrum_ctrl(spread_spectrum_ctrl),
    .output_frequency_select(output_frequency_select), .display_enable(display_enable)
  );
  task automatic chk(input string name, input logic [1143:0] exp, input logic [1143:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  // Writes a header and then, when n is above zero, a register address and n data bytes (at most two).
  task automatic wr(input logic [7:0] h, input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1, input int n);
    logic a;
    host.start();
    host.put({5'h0D, lo, 1'b0}, a);
    chk("ack address", 1'b1, a);
    host.put(h, a);
    chk("ack header", 1'b1, a);
    if (n > 0) begin
      host.put(r, a);
      chk("ack register", 1'b1, a);
      host.put(d0, a);
      chk("ack data", 1'b1, a);
    end
    if (n > 1) begin
      host.put(d1, a);
      chk("ack second data", 1'b1, a);
    end
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] h, input logic [7:0] r, output logic [7:0] d);
    logic a;
    host.start();
    host.put({5'h0D, lo, 1'b0}, a);
    host.put(h, a);
    host.put(r, a);
    host.start();
    host.put({5'h0D, lo, 1'b1}, a);
    chk("ack read address", 1'b1, a);
    host.get(1'b0, d);
    host.stop();
  endtask : rd
  task automatic t_reset();
    chk("dot duty", '0, dot_duty);
    chk("sink scale", '0, sink_scale_value);
    chk("config", 8'h00, operating_config);
    chk("current", 7'h00, global_current_code);
    chk("pull", 8'h33, pull_resistor_select);
    chk("spread", 8'h00, spread_spectrum_ctrl);
    chk("frequency", 8'h01, output_frequency_select);
    chk("display enable", 1'b0, display_enable);
    $display("reset test done");
  endtask : t_reset
  task automatic t_addr();
    logic a;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      ad_level        <= (i < 4) ? i[1:0] : 2'h3;
      ad_is_touch_key <= (i == 4);
      lo = (i < 4) ? i[1:0] : 2'h0;
      host.start();
      host.put({5'h0D, lo, 1'b0}, a);
      chk("ack own address", 1'b1, a);
      host.stop();
      host.start();
      host.put((i < 4) ? {5'h1D, lo, 1'b0} : {5'h0D, 2'h3, 1'b0}, a);
      chk("ack foreign address", 1'b0, a);
      host.stop();
    end
    $display("address test done");
  endtask : t_addr
  task automatic t_write();
    wr(8'h55, 8'hA0, 8'h01, 8'h7F, 2);
    chk("config", 8'h01, operating_config);
    chk("current clamp", 7'h40, global_current_code);
    chk("display enable", 1'b1, display_enable);
    wr(8'h55, 8'h8F, 8'h11, 8'h22, 2);
    chk("last dot", 8'h11, dot_duty[1143:1136]);
    chk("first sink", 8'h22, sink_scale_value[7:0]);
    wr(8'h55, 8'hB1, 8'h5A, 8'h06, 2);
    chk("spread", 8'h5A, spread_spectrum_ctrl);
    chk("frequency", 8'h06, output_frequency_select);
    $display("write test done");
  endtask : t_write
  task automatic t_read();
    logic [7:0] d;
    rd(8'h55, 8'hB0, d);
    chk("read pull", 8'h33, d);
    @(posedge ref_clk);
    fault_results <= {8'h3C, 128'h0, 8'hC3};
    fault_load    <= 1'b1;
    @(posedge ref_clk);
    fault_load <= 1'b0;
    rd(8'h55, 8'hB3, d);
    chk("read first fault", 8'hC3, d);
    rd(8'h55, 8'hC4, d);
    chk("read last fault", 8'h3C, d);
    $display("read test done");
  endtask : t_read
  task automatic t_header();
    wr(8'hAA, 8'hA0, 8'h00, 8'h00, 1);
    chk("config after touch header", 8'h01, operating_config);
    wr(8'h3C, 8'hA0, 8'h00, 8'h00, 1);
    chk("config after unknown header", 8'h01, operating_config);
    $display("header test done");
  endtask : t_header
  task automatic t_save();
    logic [7:0] d;
    wr(8'hA5, 8'h00, 8'h00, 8'h00, 0);
    wr(8'h55, 8'h8F, 8'h00, 8'h00, 1);
    wr(8'h55, 8'hA0, 8'h00, 8'h00, 1);
    wr(8'h55, 8'hCF, 8'h12, 8'h00, 1);
    chk("config after wrong key", 8'h00, operating_config);
    wr(8'h55, 8'hCF, 8'hAE, 8'h00, 1);
    chk("config restored", 8'h01, operating_config);
    chk("dot restored", 8'h11, dot_duty[1143:1136]);
    chk("pull restored", 8'h33, pull_resistor_select);
    rd(8'h55, 8'hB3, d);
    chk("fault cleared", 8'h00, d);
    $display("save test done");
  endtask : t_save
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_addr();
    t_write();
    t_read();
    t_header();
    t_save();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
